// [hdl/csf_pkg.sv]
package csf_pkg;

  // Address of the status register on the register port.
  localparam logic [7:0] STATUS_ADDR = 8'h03;

  // Value after power-up: reset-cause flags set, all else clear.
  localparam logic [7:0] STATUS_RST = 8'h18;

  // Bits that no instruction result or register write may change.
  localparam logic [7:0] RO_MASK = 8'h18;

  // Field positions inside the status register.
  localparam int BIT_C    = 0;
  localparam int BIT_DIGC = 1;
  localparam int BIT_Z    = 2;
  localparam int BIT_PDN  = 3;
  localparam int BIT_TMO  = 4;
  localparam int BIT_BANK = 5;
  localparam int BANK_W   = 2;
  localparam int BIT_RSVD = 7;

  // Width of the low-order digit watched by the digit carry.
  localparam int NIB_W = 4;

  // Operations presented by the execution datapath.
  typedef enum logic [3:0] {
    OP_NONE       = 4'h0,
    OP_ADD_REG    = 4'h1,
    OP_ADD_LIT    = 4'h2,
    OP_SUB_LIT    = 4'h3,
    OP_SUB_REG    = 4'h4,
    OP_AND        = 4'h5,
    OP_IOR        = 4'h6,
    OP_XOR        = 4'h7,
    OP_CLEAR_FILE = 4'h8,
    OP_MOVE_W     = 4'h9,
    OP_BIT_CLEAR  = 4'hA,
    OP_BIT_SET    = 4'hB,
    OP_SWAP       = 4'hC,
    OP_INCR       = 4'hD,
    OP_WDT_CLEAR  = 4'hE,
    OP_SLEEP      = 4'hF
  } csf_op_t;

endpackage

// [hdl/csf_alu_if.sv]
`timescale 1ns/1ps
interface csf_alu_if;

  // Request towards the flag logic and its answer.
  csf_pkg::csf_op_t op;
  logic [7:0]       opnd_w;
  logic [7:0]       opnd_f;
  logic [2:0]       bit_sel;
  logic [7:0]       result;
  logic             z;
  logic             digc;
  logic             c;
  logic             aff_z;
  logic             aff_digc;
  logic             aff_c;

  modport core (
    output op, opnd_w, opnd_f, bit_sel,
    input  result, z, digc, c, aff_z, aff_digc, aff_c
  );

  modport alu (
    input  op, opnd_w, opnd_f, bit_sel,
    output result, z, digc, c, aff_z, aff_digc, aff_c
  );

endinterface

// [hdl/csf_alu.sv]
`timescale 1ns/1ps
module csf_alu (
  csf_alu_if.alu io
);

  logic       is_sub;
  logic [7:0] addend;
  logic [8:0] sum;
  logic [4:0] nib;

  // Subtraction adds the two's complement of the working operand.
  always_comb
  begin
    is_sub = (io.op == csf_pkg::OP_SUB_LIT) || (io.op == csf_pkg::OP_SUB_REG);
    addend = is_sub ? ~io.opnd_w : io.opnd_w;
    sum    = {1'b0, io.opnd_f} + {1'b0, addend} + {8'h00, is_sub};
    nib    = {1'b0, io.opnd_f[csf_pkg::NIB_W-1:0]}
           + {1'b0, addend[csf_pkg::NIB_W-1:0]} + {4'h0, is_sub};
  end

  // Result and the set of flags each operation touches.
  always_comb
  begin
    io.result = io.opnd_f;
    io.aff_z  = 1'b0;
    io.aff_digc = 1'b0;
    io.aff_c  = 1'b0;
    unique case (io.op)
      csf_pkg::OP_ADD_REG, csf_pkg::OP_ADD_LIT,
      csf_pkg::OP_SUB_LIT, csf_pkg::OP_SUB_REG:
      begin
        io.result = sum[7:0];
        io.aff_z  = 1'b1;
        io.aff_digc = 1'b1;
        io.aff_c  = 1'b1;
      end
      csf_pkg::OP_AND:        begin io.result = io.opnd_f & io.opnd_w; io.aff_z = 1'b1; end
      csf_pkg::OP_IOR:        begin io.result = io.opnd_f | io.opnd_w; io.aff_z = 1'b1; end
      csf_pkg::OP_XOR:        begin io.result = io.opnd_f ^ io.opnd_w; io.aff_z = 1'b1; end
      csf_pkg::OP_CLEAR_FILE: begin io.result = 8'h00; io.aff_z = 1'b1; end
      csf_pkg::OP_INCR:       begin io.result = io.opnd_f + 8'h01; io.aff_z = 1'b1; end
      csf_pkg::OP_MOVE_W:     io.result = io.opnd_w;
      csf_pkg::OP_BIT_CLEAR:  io.result = io.opnd_f & ~(8'h01 << io.bit_sel);
      csf_pkg::OP_BIT_SET:    io.result = io.opnd_f | (8'h01 << io.bit_sel);
      csf_pkg::OP_SWAP:       io.result = {io.opnd_f[3:0], io.opnd_f[7:4]};
      csf_pkg::OP_NONE, csf_pkg::OP_WDT_CLEAR, csf_pkg::OP_SLEEP:
        io.result = io.opnd_f;
    endcase
  end

  // Flag values; only the affected ones are taken by the register.
  assign io.z  = (io.result == 8'h00);
  assign io.digc = nib[csf_pkg::NIB_W];
  assign io.c  = sum[8];

endmodule

// [hdl/csf_status.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Flag-updating writes keep hardware flag values.
// - Time-out and power-down bits are never written by the port or a result; only sleep, watchdog clear and time-out move them.
// - Clear-file clears upper three, sets zero.
// - Register holds the bank select field.
// - Digit carry from fourth bit on add/subtract.
// - Carry updates only on add/subtract instructions.
// - Subtraction flags are inverted borrows.
module csf_status (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  input  wire logic             instr_valid,
  input  wire csf_pkg::csf_op_t instr_op,
  input  wire logic [7:0]       instr_w,
  input  wire logic [7:0]       instr_f,
  input  wire logic [2:0]       instr_bit,
  input  wire logic             instr_dest_status,
  input  wire logic             wdt_timeout,
  output logic      [7:0]       exec_result,
  output logic                  exec_done,
  output logic      [7:0]       status_flags,
  output logic      [1:0]       bank_select
);

  csf_alu_if alu_io ();

  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] result_q;
  logic [7:0] result_d;
  logic       done_q;
  logic       done_d;
  logic       file_op;
  logic       to_status;
  logic       bus_hit_wr;
  logic       bus_hit_rd;

  // The flag logic itself.
  csf_alu u_alu (
    .io (alu_io)
  );

  // Literal forms and the reset-cause instructions never write a file.
  always_comb
  begin
    unique case (instr_op)
      csf_pkg::OP_NONE, csf_pkg::OP_ADD_LIT, csf_pkg::OP_SUB_LIT,
      csf_pkg::OP_WDT_CLEAR, csf_pkg::OP_SLEEP:
        file_op = 1'b0;
      default:
        file_op = 1'b1;
    endcase
  end

  // An instruction aimed at the status register reads it as its source.
  assign to_status = instr_valid && instr_dest_status && file_op;

  // Operands handed to the flag logic.
  always_comb
  begin
    alu_io.op      = instr_valid ? instr_op : csf_pkg::OP_NONE;
    alu_io.opnd_w  = instr_w;
    alu_io.opnd_f  = to_status ? status_q : instr_f;
    alu_io.bit_sel = instr_bit;
  end

  // Address decode for the register port.
  assign bus_hit_wr = reg_wr && (reg_addr == csf_pkg::STATUS_ADDR);
  assign bus_hit_rd = reg_rd && (reg_addr == csf_pkg::STATUS_ADDR);

  // Next value of the status register. An instruction has priority over
  // a register-port write in the same cycle, and a watchdog time-out is
  // applied last so that it is never lost behind a watchdog clear.
  always_comb
  begin
    status_d = status_q;
    if (instr_valid)
    begin
      if (to_status)
      begin
        // Result lands in the writable bits only.
        status_d = (alu_io.result & ~csf_pkg::RO_MASK)
                 | (status_q & csf_pkg::RO_MASK);
        // The result of a flag-setting instruction lands in none of the three flags.
        if (alu_io.aff_z || alu_io.aff_digc || alu_io.aff_c)
        begin
          status_d[csf_pkg::BIT_Z:csf_pkg::BIT_C] =
            status_q[csf_pkg::BIT_Z:csf_pkg::BIT_C];
        end
      end
      // Affected flags come from the flag logic, not from the result.
      if (alu_io.aff_z)
      begin
        status_d[csf_pkg::BIT_Z] = alu_io.z;
      end
      if (alu_io.aff_digc)
      begin
        status_d[csf_pkg::BIT_DIGC] = alu_io.digc;
      end
      if (alu_io.aff_c)
      begin
        status_d[csf_pkg::BIT_C] = alu_io.c;
      end
      if (instr_op == csf_pkg::OP_WDT_CLEAR)
      begin
        status_d[csf_pkg::BIT_TMO] = 1'b1;
        status_d[csf_pkg::BIT_PDN] = 1'b1;
      end
      if (instr_op == csf_pkg::OP_SLEEP)
      begin
        status_d[csf_pkg::BIT_TMO] = 1'b1;
        status_d[csf_pkg::BIT_PDN] = 1'b0;
      end
    end
    else if (bus_hit_wr)
    begin
      // A port write acts like a flag-neutral move into the register.
      status_d = (reg_wdata & ~csf_pkg::RO_MASK)
               | (status_q & csf_pkg::RO_MASK);
    end
    if (wdt_timeout)
    begin
      status_d[csf_pkg::BIT_TMO] = 1'b0;
    end
  end

  // Status register; power-up leaves both reset-cause flags set.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      status_q <= csf_pkg::STATUS_RST;
    end
    else
    begin
      status_q <= status_d;
    end
  end

  // Read data stand for one cycle only; other addresses read as zero.
  always_comb
  begin
    rdata_d = bus_hit_rd ? status_q : 8'h00;
  end

  // Execution result goes back to the datapath one cycle later.
  always_comb
  begin
    result_d = instr_valid ? alu_io.result : result_q;
    done_d   = instr_valid;
  end

  // Registers for the port read data and the execution answer.
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rdata_q  <= 8'h00;
      result_q <= 8'h00;
      done_q   <= 1'b0;
    end
    else
    begin
      rdata_q  <= rdata_d;
      result_q <= result_d;
      done_q   <= done_d;
    end
  end

  // Outputs straight from flip-flops.
  assign reg_rdata    = rdata_q;
  assign exec_result  = result_q;
  assign exec_done    = done_q;
  assign status_flags = status_q;
  assign bank_select  = status_q[csf_pkg::BIT_BANK +: csf_pkg::BANK_W];

  // A port write never moves the reset-cause flags.
  chk_ro_port_write:
  assert property (@(posedge clock) disable iff (!rst_n)
    bus_hit_wr && !instr_valid && !wdt_timeout
    |=> status_q[4:3] == $past(status_q[4:3]))
  else $error("reset-cause flags changed by a port write");

  // An instruction into the register never moves the reset-cause flags.
  chk_ro_instr_write:
  assert property (@(posedge clock) disable iff (!rst_n)
    to_status && !wdt_timeout
    |=> status_q[4:3] == $past(status_q[4:3]))
  else $error("reset-cause flags changed by an instruction write");

  // An add register into the register keeps the flag logic values.
  chk_flag_override:
  assert property (@(posedge clock) disable iff (!rst_n)
    to_status && (instr_op == csf_pkg::OP_ADD_REG)
    |=> status_q[csf_pkg::BIT_Z]
        == (8'($past(status_q) + $past(instr_w)) == 8'h00)
     && status_q[csf_pkg::BIT_DIGC]
        == (({1'b0, $past(status_q[3:0])} + {1'b0, $past(instr_w[3:0])})
            > 5'h0F)
     && status_q[csf_pkg::BIT_C]
        == (({1'b0, $past(status_q)} + {1'b0, $past(instr_w)}) > 9'h0FF))
  else $error("written value overrode hardware flags");

  // Clear-file on the register clears the top three and sets zero.
  chk_clear_file:
  assert property (@(posedge clock) disable iff (!rst_n)
    to_status && (instr_op == csf_pkg::OP_CLEAR_FILE) && !wdt_timeout
    |=> status_q[7:5] == 3'h0 && status_q[csf_pkg::BIT_Z]
     && status_q[4:3] == $past(status_q[4:3])
     && status_q[1:0] == $past(status_q[1:0]))
  else $error("clear-file result on status is wrong");

  // The bank field takes a port write.
  chk_bank_field:
  assert property (@(posedge clock) disable iff (!rst_n)
    bus_hit_wr && !instr_valid
    |=> bank_select == $past(reg_wdata[6:5]))
  else $error("bank select field did not take the write");

  // Digit carry of an add literal is the low-digit overflow.
  chk_digit_carry:
  assert property (@(posedge clock) disable iff (!rst_n)
    instr_valid && (instr_op == csf_pkg::OP_ADD_LIT)
    |=> status_q[csf_pkg::BIT_DIGC]
        == (({1'b0, $past(instr_f[3:0])} + {1'b0, $past(instr_w[3:0])})
            > 5'h0F))
  else $error("digit carry wrong after add literal");

  // Logic, increment and swap operations leave the carry alone.
  chk_carry_only:
  assert property (@(posedge clock) disable iff (!rst_n)
    instr_valid && !instr_dest_status
    && (instr_op inside {csf_pkg::OP_AND, csf_pkg::OP_IOR,
        csf_pkg::OP_XOR, csf_pkg::OP_INCR, csf_pkg::OP_SWAP})
    |=> $stable(status_q[csf_pkg::BIT_C]))
  else $error("carry changed by a non-arithmetic instruction");

  // Subtraction leaves carry set exactly when no borrow occurred.
  chk_sub_borrow:
  assert property (@(posedge clock) disable iff (!rst_n)
    instr_valid && !instr_dest_status && (instr_op == csf_pkg::OP_SUB_REG)
    |=> status_q[csf_pkg::BIT_C] == ($past(instr_f) >= $past(instr_w)))
  else $error("carry is not the inverted borrow");

  // Zero flag after an exclusive or.
  chk_zero_flag:
  assert property (@(posedge clock) disable iff (!rst_n)
    instr_valid && !instr_dest_status && (instr_op == csf_pkg::OP_XOR)
    |=> status_q[csf_pkg::BIT_Z] == ($past(instr_f) == $past(instr_w)))
  else $error("zero flag does not follow the result");

  // Sleep sets time-out and clears power-down.
  chk_sleep_flags:
  assert property (@(posedge clock) disable iff (!rst_n)
    instr_valid && (instr_op == csf_pkg::OP_SLEEP) && !wdt_timeout
    |=> status_q[csf_pkg::BIT_TMO] && !status_q[csf_pkg::BIT_PDN])
  else $error("sleep left wrong reset-cause flags");

  // A watchdog time-out clears the time-out flag whatever else happens.
  chk_timeout_clear:
  assert property (@(posedge clock) disable iff (!rst_n)
    wdt_timeout |=> !status_q[csf_pkg::BIT_TMO])
  else $error("time-out flag not cleared by watchdog time-out");

  // Read data show the register in the next cycle, zero otherwise.
  chk_read_data:
  assert property (@(posedge clock) disable iff (!rst_n)
    reg_rd |=> reg_rdata == ($past(bus_hit_rd) ? $past(status_q) : 8'h00))
  else $error("read data wrong");

  // Execution answer follows every instruction by one cycle.
  chk_exec_done:
  assert property (@(posedge clock) disable iff (!rst_n)
    instr_valid |=> exec_done && exec_result == $past(alu_io.result))
  else $error("execution answer missing");

  // Power-up leaves the reset-cause flags set and the rest clear.
  chk_reset_value:
  assert property (@(posedge clock)
    !rst_n |=> status_flags == csf_pkg::STATUS_RST)
  else $error("status not at its power-up value after reset");

  // Carry of an add register is the carry out of the top bit.
  chk_carry_add:
  assert property (@(posedge clock) disable iff (!rst_n)
    instr_valid && !instr_dest_status && (instr_op == csf_pkg::OP_ADD_REG)
    |=> status_q[csf_pkg::BIT_C]
        == (({1'b0, $past(instr_f)} + {1'b0, $past(instr_w)}) > 9'h0FF))
  else $error("carry wrong after add register");

  // Subtract literal keeps digit carry set when no digit borrow occurs.
  chk_sub_digit:
  assert property (@(posedge clock) disable iff (!rst_n)
    instr_valid && (instr_op == csf_pkg::OP_SUB_LIT)
    |=> status_q[csf_pkg::BIT_DIGC]
        == ($past(instr_f[3:0]) >= $past(instr_w[3:0])))
  else $error("digit carry is not the inverted digit borrow");

  // Watchdog clear sets both reset-cause flags.
  chk_wdt_clear:
  assert property (@(posedge clock) disable iff (!rst_n)
    instr_valid && (instr_op == csf_pkg::OP_WDT_CLEAR) && !wdt_timeout
    |=> status_q[csf_pkg::BIT_TMO] && status_q[csf_pkg::BIT_PDN])
  else $error("watchdog clear left wrong reset-cause flags");

  // Flag-neutral instructions leave the three arithmetic flags alone.
  chk_neutral_ops:
  assert property (@(posedge clock) disable iff (!rst_n)
    instr_valid && !instr_dest_status
    && (instr_op inside {csf_pkg::OP_NONE, csf_pkg::OP_MOVE_W,
        csf_pkg::OP_BIT_CLEAR, csf_pkg::OP_BIT_SET, csf_pkg::OP_SWAP})
    |=> status_q[2:0] == $past(status_q[2:0]))
  else $error("flags changed by a flag-neutral instruction");

endmodule

// [tb/csf_core_model.sv]
`timescale 1ns/1ps
// Execution datapath stand-in that presents one instruction per request.
module csf_core_model (
  input  wire logic             clock,
  input  wire logic             req,
  input  wire csf_pkg::csf_op_t req_op,
  input  wire logic [7:0]       req_w,
  input  wire logic [7:0]       req_f,
  input  wire logic [2:0]       req_bit,
  input  wire logic             req_dest,
  output logic                  instr_valid,
  output csf_pkg::csf_op_t      instr_op,
  output logic      [7:0]       instr_w,
  output logic      [7:0]       instr_f,
  output logic      [2:0]       instr_bit,
  output logic                  instr_dest_status
);
  logic [7:0] last_w_q;
  logic [7:0] last_f_q;

  // Remember the last operands so idle cycles never repeat them.
  always_ff @(posedge clock)
  begin
    if (req)
    begin
      last_w_q <= req_w;
      last_f_q <= req_f;
    end
  end

  // Idle operands show the inverse of the last ones, not a stale copy.
  // Software keeps the two top bits clear when it aims at the status.
  always_comb
  begin
    instr_valid       = req;
    instr_op          = req ? req_op : csf_pkg::OP_NONE;
    instr_w           = req ? req_w : ~last_w_q;
    instr_f           = req ? req_f : ~last_f_q;
    instr_bit         = req ? req_bit : ~req_bit;
    instr_dest_status = req & req_dest;
    if (req && req_dest)
    begin
      instr_w = {2'b00, req_w[5:0]};
    end
  end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    csf_pkg::csf_op_t op;
    logic [7:0]       w;
    logic [7:0]       f;
    logic             cr;
    logic [7:0]       res;
    logic [7:0]       st;
  } csf_row_t;

  logic             clock;
  logic             rst_n;
  logic [7:0]       reg_addr;
  logic [7:0]       reg_wdata;
  logic             reg_wr;
  logic             reg_rd;
  logic [7:0]       reg_rdata;
  logic             instr_valid;
  csf_pkg::csf_op_t instr_op;
  logic [7:0]       instr_w;
  logic [7:0]       instr_f;
  logic [2:0]       instr_bit;
  logic             instr_dest_status;
  logic             wdt_timeout;
  logic [7:0]       exec_result;
  logic             exec_done;
  logic [7:0]       status_flags;
  logic [1:0]       bank_select;
  logic             req;
  csf_pkg::csf_op_t req_op;
  logic [7:0]       req_w;
  logic [7:0]       req_f;
  logic [2:0]       req_bit;
  logic             req_dest;
  int               bad_count;
  int               n_tests;
  csf_row_t         rows [13];

  csf_status DUT (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_w(instr_w), .instr_f(instr_f),
    .instr_bit(instr_bit), .instr_dest_status(instr_dest_status),
    .wdt_timeout(wdt_timeout), .exec_result(exec_result),
    .exec_done(exec_done), .status_flags(status_flags),
    .bank_select(bank_select));

  csf_core_model core (.clock(clock), .req(req), .req_op(req_op),
    .req_w(req_w), .req_f(req_f), .req_bit(req_bit),
    .req_dest(req_dest), .instr_valid(instr_valid),
    .instr_op(instr_op), .instr_w(instr_w), .instr_f(instr_f),
    .instr_bit(instr_bit), .instr_dest_status(instr_dest_status));

  // Free-running core clock at 250 MHz.
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk8(input string name, input logic [7:0] exp,
                      input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk8("reg_rdata", exp, reg_rdata);
    @(posedge clock);
    #1;
    chk8("reg_rdata_idle", 8'h00, reg_rdata);
  endtask

  task automatic exec(input csf_pkg::csf_op_t op, input logic [7:0] w,
                      input logic [7:0] f, input logic [2:0] b,
                      input logic dest, input logic tmo);
    @(posedge clock);
    req         <= 1'b1;
    req_op      <= op;
    req_w       <= w;
    req_f       <= f;
    req_bit     <= b;
    req_dest    <= dest;
    wdt_timeout <= tmo;
    @(posedge clock);
    req         <= 1'b0;
    wdt_timeout <= 1'b0;
    #1;
    chk1("exec_done", 1'b1, exec_done);
  endtask

  task automatic finish_test;
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog that ends a hung run as a failure.
  initial
  begin
    repeat (5000) @(posedge clock);
    bad_count++;
    finish_test;
  end

  // Main sequence: reset, table of flag cases, then hand-written cases.
  initial
  begin
    {rst_n, reg_wr, reg_rd, req, wdt_timeout, req_dest} = '0;
    {reg_addr, reg_wdata, req_w, req_f, req_bit} = '0;
    req_op = csf_pkg::OP_NONE;
    bad_count = 0;
    n_tests = 0;
    rows = '{'{csf_pkg::OP_ADD_LIT, 8'h08, 8'h08, 1'b1, 8'h10, 8'h1A},
      '{csf_pkg::OP_ADD_REG, 8'h80, 8'h80, 1'b1, 8'h00, 8'h1D},
      '{csf_pkg::OP_SWAP, 8'h00, 8'hA5, 1'b1, 8'h5A, 8'h1D},
      '{csf_pkg::OP_SUB_REG, 8'h03, 8'h05, 1'b1, 8'h02, 8'h1B},
      '{csf_pkg::OP_INCR, 8'h00, 8'hFF, 1'b1, 8'h00, 8'h1F},
      '{csf_pkg::OP_SUB_LIT, 8'h05, 8'h03, 1'b1, 8'hFE, 8'h18},
      '{csf_pkg::OP_AND, 8'h0F, 8'hF0, 1'b1, 8'h00, 8'h1C},
      '{csf_pkg::OP_IOR, 8'h01, 8'h00, 1'b1, 8'h01, 8'h18},
      '{csf_pkg::OP_SLEEP, 8'h00, 8'h00, 1'b0, 8'h00, 8'h10},
      '{csf_pkg::OP_WDT_CLEAR, 8'h00, 8'h00, 1'b0, 8'h00, 8'h18},
      '{csf_pkg::OP_XOR, 8'h3C, 8'h3C, 1'b1, 8'h00, 8'h1C},
      '{csf_pkg::OP_XOR, 8'h3C, 8'hC3, 1'b1, 8'hFF, 8'h18},
      '{csf_pkg::OP_NONE, 8'h00, 8'h77, 1'b1, 8'h77, 8'h18}};
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk8("status_flags", csf_pkg::STATUS_RST, status_flags);
    chk8("bank_select", 8'h00, {6'h00, bank_select});
    rd(csf_pkg::STATUS_ADDR, 8'h18);
    $display("test reset done");
    foreach (rows[i])
    begin
      exec(rows[i].op, rows[i].w, rows[i].f, 3'h0, 1'b0, 1'b0);
      chk8("status_flags", rows[i].st, status_flags);
      if (rows[i].cr)
        chk8("exec_result", rows[i].res, exec_result);
    end
    $display("test flag table done");
    wr(csf_pkg::STATUS_ADDR, 8'hFF);
    rd(csf_pkg::STATUS_ADDR, 8'hFF);
    chk8("bank_select", 8'h03, {6'h00, bank_select});
    wr(csf_pkg::STATUS_ADDR, 8'h00);
    chk8("status_flags", 8'h18, status_flags);
    wr(8'h04, 8'hE7);
    chk8("status_flags", 8'h18, status_flags);
    rd(8'h04, 8'h00);
    $display("test register port done");
    exec(csf_pkg::OP_ADD_REG, 8'h01, 8'h55, 3'h0, 1'b1, 1'b0);
    chk8("exec_result", 8'h19, exec_result);
    chk8("status_flags", 8'h18, status_flags);
    wr(csf_pkg::STATUS_ADDR, 8'hE7);
    exec(csf_pkg::OP_CLEAR_FILE, 8'h00, 8'h00, 3'h0, 1'b1, 1'b0);
    chk8("status_flags", 8'h1F, status_flags);
    exec(csf_pkg::OP_WDT_CLEAR, 8'h00, 8'h00, 3'h0, 1'b0, 1'b1);
    chk8("status_flags", 8'h0F, status_flags);
    exec(csf_pkg::OP_MOVE_W, 8'h3F, 8'h00, 3'h0, 1'b1, 1'b0);
    chk8("status_flags", 8'h2F, status_flags);
    chk8("bank_select", 8'h01, {6'h00, bank_select});
    $display("test status destination done");
    exec(csf_pkg::OP_BIT_CLEAR, 8'h00, 8'h00, 3'h5, 1'b1, 1'b0);
    chk8("status_flags", 8'h0F, status_flags);
    chk8("bank_select", 8'h00, {6'h00, bank_select});
    exec(csf_pkg::OP_BIT_SET, 8'h00, 8'h00, 3'h4, 1'b1, 1'b0);
    chk8("status_flags", 8'h0F, status_flags);
    exec(csf_pkg::OP_BIT_CLEAR, 8'h00, 8'h00, 3'h3, 1'b1, 1'b0);
    chk8("status_flags", 8'h0F, status_flags);
    exec(csf_pkg::OP_BIT_SET, 8'h00, 8'h00, 3'h2, 1'b0, 1'b0);
    chk8("exec_result", 8'h04, exec_result);
    chk8("status_flags", 8'h0F, status_flags);
    $display("test bit instructions done");
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk8("status_flags", csf_pkg::STATUS_RST, status_flags);
    chk8("exec_result", 8'h00, exec_result);
    chk1("exec_done", 1'b0, exec_done);
    $display("test mid-run reset done");
    finish_test;
  end
endmodule
